// *** verilog/adc_ctrl_pkg.sv ***
// package: register map, fields and reset values of the converter control bank
package adc_ctrl_pkg;
  localparam int ADDR_W = 9;
  localparam logic [8:0] OFS_SEL_LOW = 9'h004;
  localparam logic [8:0] OFS_SEL_HIGH = 9'h005;
  localparam logic [8:0] OFS_PWR_MODE = 9'h008;
  localparam logic [8:0] OFS_PATT1_LOW = 9'h019;
  localparam logic [8:0] OFS_PATT1_HIGH = 9'h01a;
  localparam logic [8:0] OFS_PATT2_LOW = 9'h01b;
  localparam logic [8:0] OFS_PATT2_HIGH = 9'h01c;
  localparam logic [8:0] OFS_STREAM = 9'h021;
  localparam logic [8:0] OFS_CHAN_PR = 9'h022;
  localparam logic [8:0] OFS_STROBE = 9'h0ff;
  localparam logic [8:0] OFS_OVERRIDE = 9'h100;
  localparam logic [8:0] OFS_IO2 = 9'h101;
  localparam logic [8:0] OFS_IO3 = 9'h102;
  localparam logic [8:0] OFS_SYNC = 9'h109;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_STREAM = 8'h41;
  localparam logic [7:0] SEL_DATA_MASK = 8'h0f;
  localparam logic [7:0] SEL_HIGH_MASK = 8'h3f;
  localparam int SEL_CLK_LSB = 4;
  localparam int PIN_FUNC_BIT = 5;
  localparam int STREAM_DDR_LSB = 4;
  localparam logic [2:0] STREAM_DDR_ONE_LANE = 3'h4;
  localparam int CH_POWER_DOWN_PIN_BIT = 0;
  localparam int CH_ORST_BIT = 1;
  localparam int OVR_ENABLE_BIT = 6;
  localparam logic [2:0] OVR_RATE_MAX = 3'h3;
  localparam int STROBE_BIT = 0;
  localparam int N_DATA = 8;
  typedef enum logic [1:0] {
    PM_NORMAL = 2'b00,
    PM_POWER_DOWN = 2'b01,
    PM_STANDBY = 2'b10,
    PM_DIGITAL_RESET = 2'b11
  } power_mode_t;
  typedef struct packed {
    logic we;
    logic [8:0] addr;
    logic [7:0] wdata;
  } reg_write_t;
  typedef struct packed {
    logic dp_clk_en;
    logic dp_reset;
    logic out_en;
    logic chip_power_down;
  } datapath_ctl_t;
endpackage

// *** verilog/adc_control_register_map.sv ***
// module: converter control register bank behind the serial port
`timescale 1ns/1ns
// Summary of operation
// - Low four index bits choose data channels
// - High index register also picks clock channels
// - Global settings hit all channels always
// - Registers except override act on write
// - Override applies only on strobe bit zero
// - Pin function bit: standby or power-down
// - Normal code keeps all channels active
// - Power-down: clocks off, reset, outputs off
// - Standby: clocks off, outputs off, no reset
// - Digital reset: datapath reset, port untouched
// - Serial port reset only by power-on
// - Stream code 100 selects DDR one lane
// - Speed upgrade request powers down chip
module adc_control_register_map (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire adc_ctrl_pkg::reg_write_t wr,
  input wire logic rd_en,
  input wire logic [8:0] rd_addr,
  input wire logic power_down_pin,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic [7:0] chan_power_down,
  output logic [7:0] chan_output_reset,
  output logic [1:0] clk_chan_sel,
  output logic [15:0] user_pattern_one,
  output logic [15:0] user_pattern_two,
  output logic [7:0] stream_ctl,
  output logic ddr_one_lane,
  output logic [7:0] override_active,
  output logic [7:0] io_ctl_two,
  output logic [7:0] io_ctl_three,
  output logic [7:0] sync_ctl,
  output adc_ctrl_pkg::datapath_ctl_t dp_ctl,
  output adc_ctrl_pkg::power_mode_t eff_mode
);
  import adc_ctrl_pkg::*;

  // ==========================================================
  // register storage
  // rst_b is the power-on reset; mode codes never touch this bank
  logic [7:0] sel_low_r, sel_low_nxt;
  logic [7:0] sel_high_r, sel_high_nxt;
  logic [7:0] pwr_r, pwr_nxt;
  logic [7:0] patt_r [4];
  logic [7:0] patt_nxt [4];
  logic [7:0] stream_r, stream_nxt;
  logic [7:0] chpr_r [N_DATA];
  logic [7:0] chpr_nxt [N_DATA];
  logic [7:0] ovr_shadow_r, ovr_shadow_nxt;
  logic [7:0] ovr_active_r, ovr_active_nxt;
  logic [7:0] io2_r, io2_nxt;
  logic [7:0] io3_r, io3_nxt;
  logic [7:0] sync_r, sync_nxt;
  logic [7:0] rd_data_r, rd_data_nxt;
  logic rd_valid_r, rd_valid_nxt;
  logic [2:0] pin_s1_r, pin_s1_nxt;
  logic pin_level_r, pin_level_nxt;
  datapath_ctl_t dp_r, dp_nxt;
  power_mode_t mode_r, mode_nxt;
  logic [7:0] data_sel;
  logic upgrade;
  power_mode_t req_mode;

  // data channel select
  // low index picks channels 0-3, high index picks channels 4-7
  assign data_sel = {sel_high_r[3:0], sel_low_r[3:0]};

  always_comb begin
    sel_low_nxt = sel_low_r;
    sel_high_nxt = sel_high_r;
    pwr_nxt = pwr_r;
    patt_nxt = patt_r;
    stream_nxt = stream_r;
    chpr_nxt = chpr_r;
    ovr_shadow_nxt = ovr_shadow_r;
    ovr_active_nxt = ovr_active_r;
    io2_nxt = io2_r;
    io3_nxt = io3_r;
    sync_nxt = sync_r;
    if (wr.we) begin
      case (wr.addr)
        OFS_SEL_LOW: sel_low_nxt = wr.wdata & SEL_DATA_MASK;
        OFS_SEL_HIGH: sel_high_nxt = wr.wdata & SEL_HIGH_MASK;
        OFS_PWR_MODE: pwr_nxt = wr.wdata;
        OFS_PATT1_LOW: patt_nxt[0] = wr.wdata;
        OFS_PATT1_HIGH: patt_nxt[1] = wr.wdata;
        OFS_PATT2_LOW: patt_nxt[2] = wr.wdata;
        OFS_PATT2_HIGH: patt_nxt[3] = wr.wdata;
        OFS_STREAM: stream_nxt = wr.wdata;
        OFS_CHAN_PR: begin
          for (int i = 0; i < N_DATA; i++) begin
            if (data_sel[i]) begin
              chpr_nxt[i] = wr.wdata;
            end
          end
        end
        OFS_OVERRIDE: ovr_shadow_nxt = wr.wdata;
        OFS_STROBE: begin
          if (wr.wdata[STROBE_BIT]) begin
            ovr_active_nxt = ovr_shadow_r;
          end
        end
        OFS_IO2: io2_nxt = wr.wdata;
        OFS_IO3: io3_nxt = wr.wdata;
        OFS_SYNC: sync_nxt = wr.wdata;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sel_low_r <= SEL_DATA_MASK;
      sel_high_r <= SEL_HIGH_MASK;
      pwr_r <= RST_ZERO;
      patt_r <= '{default: RST_ZERO};
      stream_r <= RST_STREAM;
      chpr_r <= '{default: RST_ZERO};
      ovr_shadow_r <= RST_ZERO;
      ovr_active_r <= RST_ZERO;
      io2_r <= RST_ZERO;
      io3_r <= RST_ZERO;
      sync_r <= RST_ZERO;
    end else begin
      sel_low_r <= sel_low_nxt;
      sel_high_r <= sel_high_nxt;
      pwr_r <= pwr_nxt;
      patt_r <= patt_nxt;
      stream_r <= stream_nxt;
      chpr_r <= chpr_nxt;
      ovr_shadow_r <= ovr_shadow_nxt;
      ovr_active_r <= ovr_active_nxt;
      io2_r <= io2_nxt;
      io3_r <= io3_nxt;
      sync_r <= sync_nxt;
    end
  end

  // ==========================================================
  // read port: one cycle latency; unmapped reads zero
  always_comb begin
    rd_valid_nxt = rd_en;
    rd_data_nxt = RST_ZERO;
    if (rd_en) begin
      case (rd_addr)
        OFS_SEL_LOW: rd_data_nxt = sel_low_r;
        OFS_SEL_HIGH: rd_data_nxt = sel_high_r;
        OFS_PWR_MODE: rd_data_nxt = pwr_r;
        OFS_PATT1_LOW: rd_data_nxt = patt_r[0];
        OFS_PATT1_HIGH: rd_data_nxt = patt_r[1];
        OFS_PATT2_LOW: rd_data_nxt = patt_r[2];
        OFS_PATT2_HIGH: rd_data_nxt = patt_r[3];
        OFS_STREAM: rd_data_nxt = stream_r;
        OFS_CHAN_PR: begin
          // lowest selected channel answers
          for (int i = N_DATA - 1; i >= 0; i--) begin
            if (data_sel[i]) begin
              rd_data_nxt = chpr_r[i];
            end
          end
        end
        OFS_OVERRIDE: rd_data_nxt = ovr_shadow_r;
        OFS_IO2: rd_data_nxt = io2_r;
        OFS_IO3: rd_data_nxt = io3_r;
        OFS_SYNC: rd_data_nxt = sync_r;
        default: rd_data_nxt = RST_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rd_data_r <= RST_ZERO;
      rd_valid_r <= 1'b0;
    end else begin
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
    end
  end

  // ==========================================================
  // power mode resolution
  // pin passes three flops; a change counts when stages two and three agree
  // upgrade detection
  assign upgrade = ovr_active_r[OVR_ENABLE_BIT] && (ovr_active_r[2:0] > OVR_RATE_MAX);

  always_comb begin
    pin_s1_nxt = {pin_s1_r[1:0], power_down_pin};
    pin_level_nxt = (pin_s1_r[2] == pin_s1_r[1]) ? pin_s1_r[2] : pin_level_r;
    req_mode = power_mode_t'(pwr_r[1:0]);
    if (pin_level_r) begin
      req_mode = pwr_r[PIN_FUNC_BIT] ? PM_STANDBY : PM_POWER_DOWN;
    end
    if (upgrade) begin
      req_mode = PM_POWER_DOWN;
    end
    mode_nxt = req_mode;
    case (req_mode)
      PM_NORMAL: dp_nxt = '{dp_clk_en: 1'b1, dp_reset: 1'b0, out_en: 1'b1, chip_power_down: 1'b0};
      PM_POWER_DOWN: dp_nxt = '{dp_clk_en: 1'b0, dp_reset: 1'b1, out_en: 1'b0, chip_power_down: 1'b1};
      PM_STANDBY: dp_nxt = '{dp_clk_en: 1'b0, dp_reset: 1'b0, out_en: 1'b0, chip_power_down: 1'b0};
      PM_DIGITAL_RESET: dp_nxt = '{dp_clk_en: 1'b1, dp_reset: 1'b1, out_en: 1'b0, chip_power_down: 1'b0};
      default: dp_nxt = '{dp_clk_en: 1'b0, dp_reset: 1'b1, out_en: 1'b0, chip_power_down: 1'b1};
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pin_s1_r <= 3'h0;
      pin_level_r <= 1'b0;
      mode_r <= PM_NORMAL;
      dp_r <= '{dp_clk_en: 1'b1, dp_reset: 1'b0, out_en: 1'b1, chip_power_down: 1'b0};
    end else begin
      pin_s1_r <= pin_s1_nxt;
      pin_level_r <= pin_level_nxt;
      mode_r <= mode_nxt;
      dp_r <= dp_nxt;
    end
  end

  // ==========================================================
  // outputs
  always_comb begin
    for (int i = 0; i < N_DATA; i++) begin
      chan_power_down[i] = chpr_r[i][CH_POWER_DOWN_PIN_BIT];
      chan_output_reset[i] = chpr_r[i][CH_ORST_BIT];
    end
  end
  assign clk_chan_sel = sel_high_r[SEL_CLK_LSB +: 2];
  assign user_pattern_one = {patt_r[1], patt_r[0]};
  assign user_pattern_two = {patt_r[3], patt_r[2]};
  assign stream_ctl = stream_r;
  assign ddr_one_lane = (stream_r[STREAM_DDR_LSB +: 3] == STREAM_DDR_ONE_LANE);
  assign override_active = ovr_active_r;
  assign io_ctl_two = io2_r;
  assign io_ctl_three = io3_r;
  assign sync_ctl = sync_r;
  assign dp_ctl = dp_r;
  assign eff_mode = mode_r;
  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  AST_OVR_HOLD: assert property (wr.we && wr.addr == OFS_OVERRIDE |=> $stable(ovr_active_r))
    else $error("override applied without strobe");
  AST_OVR_APPLY: assert property (wr.we && wr.addr == OFS_STROBE && wr.wdata[0]
    |=> ovr_active_r == $past(ovr_shadow_r))
    else $error("strobe did not apply override");
  AST_IMMEDIATE: assert property (wr.we && wr.addr == OFS_STREAM |=> stream_r == $past(wr.wdata))
    else $error("stream register not updated at once");
  AST_LOCAL: assert property (wr.we && wr.addr == OFS_CHAN_PR && !data_sel[0] |=> $stable(chpr_r[0]))
    else $error("unselected channel changed");
  AST_GLOBAL: assert property (wr.we && wr.addr == OFS_PATT1_LOW && data_sel == 8'h00
    |=> user_pattern_one[7:0] == $past(wr.wdata))
    else $error("global write gated by select");
  AST_PIN_STANDBY: assert property (pin_level_r && pwr_r[5] && !upgrade |=> eff_mode == PM_STANDBY)
    else $error("pin did not enter standby");
  AST_NORMAL: assert property (!pin_level_r && !upgrade && pwr_r[1:0] == 2'b00
    |=> dp_ctl.out_en && dp_ctl.dp_clk_en)
    else $error("normal mode not active");
  AST_POWER_DOWN_PIN: assert property (eff_mode == PM_POWER_DOWN |-> dp_ctl.dp_reset && !dp_ctl.dp_clk_en)
    else $error("power-down outputs wrong");
  AST_STBY: assert property (eff_mode == PM_STANDBY |-> !dp_ctl.dp_reset && !dp_ctl.out_en)
    else $error("standby outputs wrong");
  AST_UPGRADE: assert property (upgrade |=> dp_ctl.chip_power_down)
    else $error("upgrade did not power down");
  AST_SPI_KEPT: assert property (eff_mode == PM_DIGITAL_RESET ##1 wr.we && wr.addr == OFS_SYNC
    |=> sync_r == $past(wr.wdata))
    else $error("port blocked in digital reset");
  AST_DDR: assert property (stream_r[6:4] == 3'h4 |-> ddr_one_lane)
    else $error("ddr lane code ignored");

  COV_STROBE: cover property (wr.we && wr.addr == OFS_STROBE && wr.wdata[0]);
  COV_PIN_POWER_DOWN_PIN: cover property (eff_mode == PM_POWER_DOWN && pin_level_r);
  COV_DIG_RST: cover property (eff_mode == PM_DIGITAL_RESET);
  COV_CH_WRITE: cover property (wr.we && wr.addr == OFS_CHAN_PR && data_sel == 8'h42);
endmodule // adc_control_register_map

// *** tb/cfg_host.sv ***
// partner model: serial host issuing register writes and reads
`timescale 1ns/1ns
module cfg_host (
  input wire logic clk_sys,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  output adc_ctrl_pkg::reg_write_t wr,
  output logic rd_en,
  output logic [8:0] rd_addr
);
  import adc_ctrl_pkg::*;
  initial begin
    wr = '0;
    rd_en = 1'b0;
    rd_addr = 9'h000;
  end
  // ==========================================
  // write cycle
  // strobe write with bit zero set applies override
  task automatic put(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr <= '{we: 1'b1, addr: a, wdata: d};
    @(posedge clk_sys);
    // released lines show the inverse, so a stale value never looks valid
    wr <= '{we: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // ==========================================
  // read cycle
  task automatic get(input logic [8:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_sys);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    rd_addr <= ~a;
    #1;
    d = rd_data;
    v = rd_valid;
  endtask
endmodule // cfg_host

// *** tb/adc_control_register_map_tb_top.sv ***
// testbench: register bank driven through the host model
`timescale 1ns/1ns
module adc_control_register_map_tb_top;
  import adc_ctrl_pkg::*;
  logic clk_sys, rst_b, rd_en, rd_valid, power_down_pin, ddr_one_lane;
  logic [8:0] rd_addr;
  logic [7:0] rd_data, chan_power_down, chan_output_reset, stream_ctl, override_active;
  logic [7:0] io_ctl_two, io_ctl_three, sync_ctl;
  logic [1:0] clk_chan_sel;
  logic [15:0] user_pattern_one, user_pattern_two;
  reg_write_t wr;
  datapath_ctl_t dp_ctl;
  power_mode_t eff_mode;
  int n_mismatch = 0;
  int tests_run = 0;
  logic [8:0] ra [13] = '{9'h004, 9'h005, 9'h008, 9'h019, 9'h01a, 9'h01b, 9'h01c, 9'h021, 9'h022, 9'h100,
    9'h101, 9'h102, 9'h109};
  logic [7:0] rv [13] = '{8'h0f, 8'h3f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h41, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00};
  // expected {clk_en, reset, out_en} per power mode code
  logic [2:0] dpx [4] = '{3'b101, 3'b010, 3'b000, 3'b110};
  adc_control_register_map uut (.clk_sys(clk_sys), .rst_b(rst_b), .wr(wr), .rd_en(rd_en), .rd_addr(rd_addr),
    .power_down_pin(power_down_pin), .rd_data(rd_data), .rd_valid(rd_valid), .chan_power_down(chan_power_down),
    .chan_output_reset(chan_output_reset), .clk_chan_sel(clk_chan_sel), .user_pattern_one(user_pattern_one),
    .user_pattern_two(user_pattern_two), .stream_ctl(stream_ctl), .ddr_one_lane(ddr_one_lane),
    .override_active(override_active), .io_ctl_two(io_ctl_two), .io_ctl_three(io_ctl_three),
    .sync_ctl(sync_ctl), .dp_ctl(dp_ctl), .eff_mode(eff_mode));
  cfg_host host (.clk_sys(clk_sys), .rd_data(rd_data), .rd_valid(rd_valid), .wr(wr), .rd_en(rd_en),
    .rd_addr(rd_addr));
  // ==========================================
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    host.get(a, d, v);
    chk({7'h00, v, d}, {8'h01, exp});
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ==========================================
  // clock, reset, watchdog
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    #1_000_000;
    n_mismatch++;
    complete_run();
  end
  // ==========================================
  // scenarios
  initial begin
    rst_b = 1'b0;
    power_down_pin = 1'b0;
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int i = 0; i < 13; i++) rd(ra[i], rv[i]);
    rd(9'h0ff, 8'h00);
    host.put(9'h030, 8'h55);
    rd(9'h030, 8'h00);
    chk(16'(ddr_one_lane), 16'h0001);
    host.put(OFS_STREAM, 8'h31);
    #1 chk({7'h00, ddr_one_lane, stream_ctl}, 16'h0031);
    host.put(OFS_SEL_LOW, 8'h02);
    host.put(OFS_SEL_HIGH, 8'h00);
    host.put(OFS_CHAN_PR, 8'h03);
    #1 chk({chan_power_down, chan_output_reset}, 16'h0202);
    host.put(OFS_SEL_HIGH, 8'h34);
    host.put(OFS_CHAN_PR, 8'h01);
    #1 chk({chan_power_down, chan_output_reset}, 16'h4200);
    chk(16'(clk_chan_sel), 16'h0003);
    host.put(OFS_SEL_LOW, 8'h00);
    host.put(OFS_SEL_HIGH, 8'h30);
    host.put(OFS_PATT1_LOW, 8'h34);
    #1 chk(user_pattern_one, 16'h0034);
    host.put(OFS_PATT1_HIGH, 8'h12);
    host.put(OFS_PATT2_LOW, 8'hcd);
    host.put(OFS_PATT2_HIGH, 8'hab);
    #1 chk(user_pattern_one, 16'h1234);
    chk(user_pattern_two, 16'habcd);
    host.put(OFS_IO2, 8'h01);
    host.put(OFS_IO3, 8'h08);
    host.put(OFS_SYNC, 8'h03);
    #1 chk({io_ctl_two, io_ctl_three ^ sync_ctl}, 16'h010b);
    host.put(OFS_OVERRIDE, 8'h41);
    #1 chk(16'(override_active), 16'h0000);
    rd(OFS_OVERRIDE, 8'h41);
    host.put(OFS_STROBE, 8'h00);
    settle(1);
    chk(16'(override_active), 16'h0000);
    host.put(OFS_STROBE, 8'h01);
    settle(1);
    chk(16'(override_active), 16'h0041);
    for (int m = 0; m < 4; m++) begin
      host.put(OFS_PWR_MODE, 8'(m));
      settle(2);
      chk({eff_mode, dp_ctl.dp_clk_en, dp_ctl.dp_reset, dp_ctl.out_en}, {m[1:0], dpx[m]});
      rd(OFS_STREAM, 8'h31);
      host.put(OFS_SYNC, 8'(m));
      #1 chk(16'(sync_ctl), 16'(m));
    end
    host.put(OFS_PWR_MODE, 8'h20);
    @(posedge clk_sys);
    power_down_pin <= 1'b1;
    settle(6);
    chk(16'(eff_mode), 16'(PM_STANDBY));
    host.put(OFS_PWR_MODE, 8'h00);
    settle(6);
    chk(16'(eff_mode), 16'(PM_POWER_DOWN));
    @(posedge clk_sys);
    power_down_pin <= 1'b0;
    settle(6);
    chk(16'(eff_mode), 16'(PM_NORMAL));
    host.put(OFS_OVERRIDE, 8'h44);
    host.put(OFS_STROBE, 8'h01);
    settle(3);
    chk(16'(dp_ctl.chip_power_down), 16'h0001);
    complete_run();
  end
endmodule // adc_control_register_map_tb_top
